//--- host_model.sv
// Host side: drives the select pin and keeps the settle wait
`timescale 1ns/1ps
module host_model #(parameter WAIT = 4) (
    input  wire core_clk_i,
    input  wire want_i,
    output reg  desel_o = 1'b1,
    output reg  free_o = 1'b0
);
    integer n = 0;
    always @(posedge core_clk_i) begin
        if (want_i == desel_o) begin
            desel_o <= !want_i;
            n <= WAIT;
            free_o <= 1'b0;
        end else if (n > 0) n <= n - 1;
        else free_o <= 1'b1;
    end
endmodule

//--- select_nr.v
// Module select gating of the serial slave and the not-ready output
`timescale 1ns/1ps
`include "select_nr_defines.vh"
module select_nr #(
    parameter N_EXTRA       = `EXTRA_FAULTS,
    parameter SEL_ASSERT    = `SEL_ASSERT_CYC,
    parameter SEL_DEASSERT  = `SEL_DEASSERT_CYC
) (
    input  wire               core_clk_i,
    input  wire               reset_i,
    input  wire               tx_cdr_lol_i,
    input  wire               tx_laser_fault_i,
    input  wire               rx_cdr_lol_i,
    input  wire [N_EXTRA-1:0] extra_fault_i,
    input  wire               module_deselect_i,
    input  wire               scl_i,
    input  wire               sda_i,
    input  wire               slave_sda_oe_i,
    output wire               module_not_ready_o,
    output wire               module_not_ready_oe_o,
    output wire               slave_enable_o,
    output wire               scl_sync_o,
    output wire               sda_sync_o,
    output wire               sda_o,
    output wire               sda_oe_o,
    output wire               select_settled_o
);
    localparam W = 3 + N_EXTRA + 3;
    // Full-width copies so the counter load is a deliberate part-select
    localparam [31:0] SEL_ASSERT_32   = SEL_ASSERT;
    localparam [31:0] SEL_DEASSERT_32 = SEL_DEASSERT;
    wire [W-1:0] raw;
    wire [W-1:0] syn;
    wire [W-1:0] rv;
    assign raw = {module_deselect_i, scl_i, sda_i, extra_fault_i,
                  rx_cdr_lol_i, tx_laser_fault_i, tx_cdr_lol_i};
    // Deselect, clock and data idle high at reset; faults idle low
    assign rv  = {3'b111, {(N_EXTRA+3){1'b0}}};
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_sync
            sync2 u_sync (
                .core_clk_i (core_clk_i),
                .reset_i    (reset_i),
                .rst_val_i  (rv[g]),
                .async_i    (raw[g]),
                .sync_o     (syn[g])
            );
        end
    endgenerate
    wire desel_s;
    wire [N_EXTRA+2:0] faults_s;
    assign desel_s    = syn[W-1];
    assign scl_sync_o = syn[W-2];
    assign sda_sync_o = syn[W-3];
    assign faults_s   = syn[N_EXTRA+2:0];

    reg nr_ff;
    wire nxt_nr;
    // Three fixed terms always stay in the OR; extras widen it
    assign nxt_nr = |faults_s;
    always @(posedge core_clk_i) begin
        if (reset_i)
            nr_ff <= 1'b0;
        else
            nr_ff <= nxt_nr;
    end
    // Open-collector pin: drive low when ready, release when not ready
    assign module_not_ready_o    = 1'b0;
    assign module_not_ready_oe_o = ~nr_ff;

    reg sel_ff;
    reg [`SEL_CNT_W-1:0] cnt_ff;
    reg [`SEL_CNT_W-1:0] nxt_cnt;
    reg nxt_sel;
    always @* begin
        nxt_sel = sel_ff;
        nxt_cnt = cnt_ff;
        if (cnt_ff != {`SEL_CNT_W{1'b0}})
            nxt_cnt = cnt_ff - {{(`SEL_CNT_W-1){1'b0}}, 1'b1};
        if (~desel_s != sel_ff) begin
            nxt_sel = ~desel_s;
            // Window length tracks the host's settling wait in each direction
            nxt_cnt = desel_s ? SEL_ASSERT_32[`SEL_CNT_W-1:0]
                              : SEL_DEASSERT_32[`SEL_CNT_W-1:0];
        end
    end
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            sel_ff <= 1'b0;
            cnt_ff <= {`SEL_CNT_W{1'b0}};
        end else begin
            sel_ff <= nxt_sel;
            cnt_ff <= nxt_cnt;
        end
    end
    // Data gating acts at once on deselect, slave enable one cycle later; the settle flag is status only,
    // since overlapping waits across modules are the host's business
    assign slave_enable_o   = sel_ff;
    assign select_settled_o = (cnt_ff == {`SEL_CNT_W{1'b0}});
    assign sda_o    = 1'b0;
    assign sda_oe_o = slave_sda_oe_i & sel_ff & ~desel_s;
endmodule

//--- select_nr_defines.vh
// Constants for the module select and not-ready logic
// Contract
// - Not-ready high while data invalid
// - Not-ready ORs three loss/fault conditions
// - Extra fault terms may join the OR
// - Select low lets serial slave respond
// - Select high: no acknowledge, data released
`ifndef SELECT_NR_DEFINES_VH
`define SELECT_NR_DEFINES_VH
`define CLK_FREQ_MHZ        50
`define SEL_ASSERT_TIME_NS  2000
`define SEL_DEASSERT_TIME_NS 2000
`define SEL_ASSERT_CYC   ((`SEL_ASSERT_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define SEL_DEASSERT_CYC ((`SEL_DEASSERT_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define EXTRA_FAULTS     2
`define SEL_CNT_W        8
`define TEN_CTRL_W       16
`endif

//--- select_nr_properties.sv
// Checker for select gating and not-ready timing
`timescale 1ns/1ps
module select_nr_props #(parameter N_EXTRA = 2) (
    input wire core_clk_i, reset_i, tx_cdr_lol_i, tx_laser_fault_i, rx_cdr_lol_i,
    input wire [N_EXTRA-1:0] extra_fault_i,
    input wire module_deselect_i, slave_sda_oe_i, module_not_ready_oe_o, slave_enable_o,
    input wire sda_oe_o,
    input wire select_settled_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    wire f = tx_cdr_lol_i | tx_laser_fault_i | rx_cdr_lol_i | (|extra_fault_i);
    sequence s_sel; !module_deselect_i [*4]; endsequence
    sequence s_desel; module_deselect_i [*4]; endsequence
    property p_nr_set; f [*4] |-> !module_not_ready_oe_o; endproperty
    property p_nr_clr; !f [*4] |-> module_not_ready_oe_o; endproperty
    property p_en; s_sel |-> slave_enable_o; endproperty
    property p_ack; s_sel ##0 slave_sda_oe_i |-> sda_oe_o; endproperty
    property p_quiet; s_desel |-> !sda_oe_o && !slave_enable_o; endproperty
    sequence s_unsettled; !select_settled_o [*4]; endsequence
    property p_settle; $changed(slave_enable_o) |-> s_unsettled; endproperty
    a_nr_set: assert property (p_nr_set) else $error("nr low");
    a_nr_clr: assert property (p_nr_clr) else $error("nr high");
    a_en: assert property (p_en) else $error("no enable");
    a_ack: assert property (p_ack) else $error("no ack");
    a_quiet: assert property (p_quiet) else $error("sda held");
    a_settle: assert property (p_settle) else $error("settle short");
endmodule
bind select_nr select_nr_props #(.N_EXTRA(N_EXTRA)) u_props (.*);

//--- select_nr_tb.sv
// Bench for select gating and not-ready
`timescale 1ns/1ps
module select_nr_tb;
    reg core_clk_i = 0, reset_i = 1, want = 0, soe = 0, scl = 1;
    reg [4:0] f = 0;
    wire ds, fr, nr, en, oe, ss, sds, st, nro, sdo;
    integer err_total = 0, total_checks = 0, cyc = 0, i;
    always #10 core_clk_i = ~core_clk_i;
    host_model u_host_model (.core_clk_i(core_clk_i), .want_i(want), .desel_o(ds), .free_o(fr));
    select_nr #(.SEL_ASSERT(4), .SEL_DEASSERT(4)) u_select_nr (.core_clk_i(core_clk_i),
        .reset_i(reset_i), .tx_cdr_lol_i(f[0]), .tx_laser_fault_i(f[1]), .rx_cdr_lol_i(f[2]),
        .extra_fault_i(f[4:3]), .module_deselect_i(ds), .scl_i(scl), .sda_i(~oe),
        .slave_sda_oe_i(soe), .module_not_ready_o(nro), .module_not_ready_oe_o(nr),
        .slave_enable_o(en), .scl_sync_o(ss), .sda_sync_o(sds), .sda_o(sdo), .sda_oe_o(oe),
        .select_settled_o(st));
    task chk(input ok);
        begin
            total_checks = total_checks + 1;
            if (!ok) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: mismatch", $time);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d errors %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task t_faults;
        for (i = 0; i < 5; i = i + 1) begin
            f <= 5'h01 << i;
            repeat (5) @(posedge core_clk_i);
            chk(nr === 1'b0);
            f <= 5'h00;
            repeat (5) @(posedge core_clk_i);
            chk(nr === 1'b1);
            chk(nro === 1'b0);
        end
    endtask
    task t_sel(input s);
        begin
            soe <= 1'b1;
            want <= s;
            repeat (2) @(posedge core_clk_i);
            for (i = 0; i < 50 && !fr; i = i + 1) @(posedge core_clk_i);
            chk(en === s && oe === s);
            chk(st === 1'b0);
            repeat (4) @(posedge core_clk_i);
            chk(st === 1'b1);
            chk(sds === ~oe && sdo === 1'b0);
        end
    endtask
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total = err_total + 1;
            end_of_test;
        end
    end
    initial begin
        repeat (4) @(posedge core_clk_i);
        reset_i <= 1'b0;
        t_faults;
        t_sel(1'b1);
        repeat (16) begin
            scl <= ~scl;
            repeat (4) @(posedge core_clk_i);
            chk(ss === scl);
        end
        chk(ss === 1'b1);
        t_sel(1'b0);
        end_of_test;
    end
endmodule

//--- sync2.v
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
module sync2 (
    input  wire core_clk_i,
    input  wire reset_i,
    input  wire rst_val_i,
    input  wire async_i,
    output wire sync_o
);
    reg meta_ff;
    reg sync_ff;
    // Reset value comes from a constant at the instance
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            meta_ff <= rst_val_i;
            sync_ff <= rst_val_i;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end
    assign sync_o = sync_ff;
endmodule
